/* rtl/arioc_consts.svh */
// Register map, field positions, reset values and timing counts of the recloser I/O block
`ifndef ARIOC_CONSTS_SVH
`define ARIOC_CONSTS_SVH
`define ARIOC_ADR_CTRL 8'h00
`define ARIOC_ADR_DEAD 8'h04
`define ARIOC_ADR_RECLAIM 8'h08
`define ARIOC_ADR_EVT_EN 8'h0c
`define ARIOC_ADR_STATUS 8'h10
`define ARIOC_ADR_IRQ_STAT 8'h14
`define ARIOC_ADR_IRQ_MASK 8'h18
`define ARIOC_ADR_CNT_CLR 8'h1c
`define ARIOC_ADR_CNT_BASE 8'h20
`define ARIOC_CTRL_SW_EN 0
`define ARIOC_CTRL_USE_EN 1
`define ARIOC_CTRL_RST 2'h1
`define ARIOC_DEAD_RST 16'h00c8
`define ARIOC_RECLAIM_RST 16'h2710
`define ARIOC_EVT_W 13
`define ARIOC_EVT_EN_RST 13'h1fff
`define ARIOC_IRQ_W 4
`define ARIOC_IRQ_SHOT 0
`define ARIOC_IRQ_LOCK 1
`define ARIOC_IRQ_FAIL 2
`define ARIOC_IRQ_EVT 3
`define ARIOC_IRQ_MASK_RST 4'h0
`define ARIOC_TICK_NS 1000000
`define ARIOC_CLK_NS 25
`define ARIOC_MS_CYCLES (`ARIOC_TICK_NS / `ARIOC_CLK_NS)
`endif

/* rtl/arioc_pkg.sv */
// Types shared by the recloser I/O block
package arioc_pkg;
   typedef enum logic [6:0] {
      ST_OFF = 7'h01,
      ST_READY = 7'h02,
      ST_OPENING = 7'h04,
      ST_DEAD = 7'h08,
      ST_CLOSING = 7'h10,
      ST_RECLAIM = 7'h20,
      ST_LOCKED = 7'h40
   } arioc_state_type;
endpackage

/* rtl/arioc_top.sv */
// Recloser I/O control: requests, lock inputs, breaker commands, events, counters
// Functional notes
// - Drive separate open and close commands toward the breaker object.
// - Emit ON/OFF events with millisecond timestamp for commands and operational signals.
// - Keep cumulative counters for applied shots and each request source, clearable.
// - Manual open or close during a sequence resets the recloser; the code ignores manual open while opening and manual close while closing.
// - Manual close in dead time enters reclaim, then locks out.
// - Opening or closing supervision failure reported by object control locks out.
// - Recloser stays off unless the breaker object is configured.
// - Enable input switches recloser only when configured as used.
// - Manual unlock input releases the locked state.
// - Lock input forces locked state; only manual unlock returns to ready.
// - Critical request moves straight to locked without any shot.
// - Five requests ranked by strict priority, first highest.
// - A shot starts when a request becomes active and conditions hold.
// - Changes of the requests and of the enable, unlock, lock and critical inputs produce a recorded event.
// - Each event source individually enabled or suppressed by configuration.
// - Settings changed mid-sequence take effect for the running sequence.
// - Ready indication high whenever a sequence could start.
`include "arioc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module arioc_top import arioc_pkg::*; #(
   parameter int MS_CYCLES = `ARIOC_MS_CYCLES,
   parameter int CNT_W = 16,
   parameter int STAMP_W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [4:0] request_prio_i,
   input wire logic recloser_enable_in_i,
   input wire logic recloser_unlock_in_i,
   input wire logic recloser_lock_in_i,
   input wire logic critical_lockout_in_i,
   input wire logic object_configured_i,
   input wire logic breaker_closed_i,
   input wire logic manual_open_i,
   input wire logic manual_close_i,
   input wire logic open_fail_i,
   input wire logic close_fail_i,
   output logic object_open_o,
   output logic object_close_o,
   output logic recloser_ready_ind_o,
   output logic event_valid_o,
   output logic [`ARIOC_EVT_W-1:0] event_change_o,
   output logic [`ARIOC_EVT_W-1:0] event_level_o,
   output logic [STAMP_W-1:0] event_stamp_o,
   output logic irq_o
);
   localparam int DIV_W = $clog2(MS_CYCLES + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   arioc_state_type state, next_state;
   logic [1:0] ctrl;
   logic [15:0] dead_ms, reclaim_ms, timer_ms, limit_ms;
   logic [`ARIOC_EVT_W-1:0] evt_en, watch, watch_q, evt_hit;
   logic [`ARIOC_IRQ_W-1:0] irq_stat, irq_mask, irq_set;
   logic [4:0] req_q, req_rise;
   logic [2:0] src, pick;
   logic [DIV_W-1:0] div_cnt;
   logic [STAMP_W-1:0] stamp;
   logic [CNT_W-1:0] cnt [6];
   logic [5:0] cnt_inc;
   logic [31:0] rd_data, wmask;
   logic ms_tick, enabled, shot_ok, shot_start, sup_fail, lock_pending;
   logic wb_req, wr_req, cnt_clr, time_up;

   // Bus handshake: one request per ack, answered one cycle later
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_req = wb_req & wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign cnt_clr = wr_req & (wb_adr_i == `ARIOC_ADR_CNT_CLR) & wb_sel_i[0] & wb_dat_i[0];

   assign enabled = ctrl[`ARIOC_CTRL_SW_EN] &
                    (~ctrl[`ARIOC_CTRL_USE_EN] | recloser_enable_in_i);
   assign shot_ok = object_configured_i & enabled;
   assign req_rise = request_prio_i & ~req_q;
   assign limit_ms = (state == ST_DEAD) ? dead_ms : reclaim_ms;
   assign time_up = (timer_ms >= limit_ms);
   assign shot_start = (state == ST_READY) & (next_state == ST_OPENING);
   assign sup_fail = ((state == ST_OPENING) & open_fail_i) |
                     ((state == ST_CLOSING) & close_fail_i);

   // Lowest index wins, so the first request outranks the rest
   always_comb begin
      pick = 3'h0;
      for (int i = 4; i >= 0; i--) begin
         if (req_rise[i]) begin
            pick = 3'(i + 1);
         end
      end
   end

   always_comb begin
      next_state = state;
      if (critical_lockout_in_i) begin
         next_state = ST_LOCKED;
      end else if (recloser_lock_in_i) begin
         next_state = ST_LOCKED;
      end else if (!shot_ok && state != ST_LOCKED) begin
         next_state = ST_OFF;
      end else begin
         case (state)
            ST_OFF: begin
               if (shot_ok) begin
                  next_state = ST_READY;
               end
            end
            ST_READY: begin
               if (pick != 3'h0) begin
                  next_state = ST_OPENING;
               end
            end
            ST_OPENING: begin
               if (open_fail_i) begin
                  next_state = ST_LOCKED;
               end else if (manual_close_i) begin
                  next_state = ST_READY;
               end else if (!breaker_closed_i) begin
                  next_state = ST_DEAD;
               end
            end
            ST_DEAD: begin
               if (manual_close_i) begin
                  next_state = ST_RECLAIM;
               end else if (manual_open_i) begin
                  next_state = ST_READY;
               end else if (time_up) begin
                  next_state = ST_CLOSING;
               end
            end
            ST_CLOSING: begin
               if (close_fail_i) begin
                  next_state = ST_LOCKED;
               end else if (manual_open_i) begin
                  next_state = ST_READY;
               end else if (breaker_closed_i) begin
                  next_state = ST_RECLAIM;
               end
            end
            ST_RECLAIM: begin
               // A returning fault here is treated as a final trip
               if (lock_pending || pick != 3'h0) begin
                  if (time_up || pick != 3'h0) begin
                     next_state = ST_LOCKED;
                  end
               end else if (manual_open_i || manual_close_i) begin
                  next_state = ST_READY;
               end else if (time_up) begin
                  next_state = ST_READY;
               end
            end
            ST_LOCKED: begin
               // Unlocking while unable to run goes to off, so ready never shows falsely
               if (recloser_unlock_in_i) begin
                  next_state = shot_ok ? ST_READY : ST_OFF;
               end
            end
            default: begin
               next_state = ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_OFF;
         object_open_o <= 1'b0;
         object_close_o <= 1'b0;
         recloser_ready_ind_o <= 1'b0;
      end else begin
         state <= next_state;
         object_open_o <= (next_state == ST_OPENING);
         object_close_o <= (next_state == ST_CLOSING);
         recloser_ready_ind_o <= (next_state == ST_READY);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src <= 3'h0;
         lock_pending <= 1'b0;
         req_q <= 5'h00;
      end else begin
         req_q <= request_prio_i;
         if (shot_start) begin
            src <= pick;
         end else if (next_state == ST_READY || next_state == ST_LOCKED) begin
            src <= 3'h0;
         end
         if (state == ST_DEAD && next_state == ST_RECLAIM) begin
            lock_pending <= 1'b1;
         end else if (next_state != ST_RECLAIM) begin
            lock_pending <= 1'b0;
         end
      end
   end

   // Millisecond tick and free-running stamp
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= '0;
         ms_tick <= 1'b0;
         stamp <= '0;
      end else begin
         ms_tick <= (div_cnt == DIV_LAST);
         div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
         if (ms_tick) begin
            stamp <= stamp + 1'b1;
         end
      end
   end

   // Timer restarts on every state change; the live setting is compared each cycle
   always_ff @(posedge clk_i) begin
      if (rst_i || next_state != state) begin
         timer_ms <= 16'h0000;
      end else if (ms_tick && timer_ms != 16'hffff) begin
         timer_ms <= timer_ms + 16'h0001;
      end
   end

   assign watch = {critical_lockout_in_i, recloser_lock_in_i, recloser_unlock_in_i,
                   recloser_enable_in_i, request_prio_i, (state == ST_LOCKED),
                   recloser_ready_ind_o, object_close_o, object_open_o};
   assign evt_hit = (watch ^ watch_q) & evt_en;

   // All simultaneous changes leave in one record, so none is dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         watch_q <= '0;
         event_valid_o <= 1'b0;
         event_change_o <= '0;
         event_level_o <= '0;
         event_stamp_o <= '0;
      end else begin
         watch_q <= watch;
         event_valid_o <= |evt_hit;
         event_change_o <= evt_hit;
         event_level_o <= watch;
         event_stamp_o <= stamp;
      end
   end

   assign cnt_inc[0] = shot_start;
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_cnt
         if (g > 0) begin : g_src
            assign cnt_inc[g] = shot_start & (pick == 3'(g));
         end
         always_ff @(posedge clk_i) begin
            if (rst_i || cnt_clr) begin
               cnt[g] <= '0;
            end else if (cnt_inc[g] && cnt[g] != CNT_MAX) begin
               cnt[g] <= cnt[g] + 1'b1;
            end
         end
      end
   endgenerate

   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         `ARIOC_ADR_CTRL: rd_data[1:0] = ctrl;
         `ARIOC_ADR_DEAD: rd_data[15:0] = dead_ms;
         `ARIOC_ADR_RECLAIM: rd_data[15:0] = reclaim_ms;
         `ARIOC_ADR_EVT_EN: rd_data[`ARIOC_EVT_W-1:0] = evt_en;
         `ARIOC_ADR_STATUS: rd_data[11:0] = {lock_pending, src, 1'b0, state};
         `ARIOC_ADR_IRQ_STAT: rd_data[`ARIOC_IRQ_W-1:0] = irq_stat;
         `ARIOC_ADR_IRQ_MASK: rd_data[`ARIOC_IRQ_W-1:0] = irq_mask;
         default: begin
            for (int k = 0; k < 6; k++) begin
               if (wb_adr_i == 8'(`ARIOC_ADR_CNT_BASE + 4 * k)) begin
                  rd_data[CNT_W-1:0] = cnt[k];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `ARIOC_CTRL_RST;
         dead_ms <= `ARIOC_DEAD_RST;
         reclaim_ms <= `ARIOC_RECLAIM_RST;
         evt_en <= `ARIOC_EVT_EN_RST;
         irq_mask <= `ARIOC_IRQ_MASK_RST;
      end else if (wr_req) begin
         case (wb_adr_i)
            `ARIOC_ADR_CTRL: ctrl <= (ctrl & ~wmask[1:0]) | (wb_dat_i[1:0] & wmask[1:0]);
            `ARIOC_ADR_DEAD: dead_ms <= (dead_ms & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            `ARIOC_ADR_RECLAIM: begin
               reclaim_ms <= (reclaim_ms & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            end
            `ARIOC_ADR_EVT_EN: begin
               evt_en <= (evt_en & ~wmask[`ARIOC_EVT_W-1:0]) |
                         (wb_dat_i[`ARIOC_EVT_W-1:0] & wmask[`ARIOC_EVT_W-1:0]);
            end
            `ARIOC_ADR_IRQ_MASK: begin
               irq_mask <= (irq_mask & ~wmask[`ARIOC_IRQ_W-1:0]) |
                           (wb_dat_i[`ARIOC_IRQ_W-1:0] & wmask[`ARIOC_IRQ_W-1:0]);
            end
            default: begin
            end
         endcase
      end
   end

   assign irq_set[`ARIOC_IRQ_SHOT] = shot_start;
   assign irq_set[`ARIOC_IRQ_LOCK] = (next_state == ST_LOCKED) & (state != ST_LOCKED);
   assign irq_set[`ARIOC_IRQ_FAIL] = sup_fail;
   assign irq_set[`ARIOC_IRQ_EVT] = |evt_hit;

   // A new event in the clearing read's cycle survives the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= '0;
         irq_o <= 1'b0;
      end else begin
         if (wb_req && !wb_we_i && wb_adr_i == `ARIOC_ADR_IRQ_STAT) begin
            irq_stat <= irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_crit_locks: assert property (critical_lockout_in_i |=> state == ST_LOCKED)
      else $error("critical request did not lock");
   a_lock_input: assert property (recloser_lock_in_i |=> state == ST_LOCKED && !object_open_o)
      else $error("lock input did not lock");
   a_unlock_ready: assert property ((state == ST_LOCKED && recloser_unlock_in_i && shot_ok &&
      !recloser_lock_in_i && !critical_lockout_in_i) |=> recloser_ready_ind_o)
      else $error("unlock did not reach ready");
   a_no_object: assert property ((!object_configured_i && !critical_lockout_in_i && !recloser_lock_in_i && state != ST_LOCKED) |=> state == ST_OFF && !object_open_o && !object_close_o)
      else $error("ran without configured object");
   a_enable_gate: assert property ((ctrl[`ARIOC_CTRL_USE_EN] && !recloser_enable_in_i && !critical_lockout_in_i && !recloser_lock_in_i && state == ST_READY) |=> state == ST_OFF)
      else $error("enable input ignored");
   a_ready_track: assert property (recloser_ready_ind_o |->
      state == ST_READY && $past(shot_ok))
      else $error("ready indication wrong");
   a_shot_prio: assert property ((state == ST_READY && shot_ok && req_rise[0] && !critical_lockout_in_i && !recloser_lock_in_i) |=> object_open_o && src == 3'h1)
      else $error("first request not chosen");
   a_shot_start: assert property ((state == ST_READY && shot_ok && req_rise != 5'h00 && !critical_lockout_in_i && !recloser_lock_in_i) |=> object_open_o ##1 irq_stat[`ARIOC_IRQ_SHOT])
      else $error("shot not applied");
   a_fail_lock: assert property ((state == ST_CLOSING && close_fail_i && shot_ok) |=> state == ST_LOCKED && !object_close_o)
      else $error("close failure not acted on");
   a_open_fail: assert property ((state == ST_OPENING && open_fail_i && shot_ok) |=>
      state == ST_LOCKED && !object_open_o)
      else $error("open failure not acted on");
   a_manual_dead: assert property ((state == ST_DEAD && manual_close_i && shot_ok && !critical_lockout_in_i && !recloser_lock_in_i) |=> state == ST_RECLAIM && lock_pending)
      else $error("manual close in dead time mishandled");
   a_manual_reset: assert property ((state == ST_CLOSING && manual_open_i && !close_fail_i && shot_ok && !critical_lockout_in_i && !recloser_lock_in_i) |=> state == ST_READY)
      else $error("manual open did not reset");
   a_cnt_clear: assert property (cnt_clr |=> cnt[0] == '0 && cnt[1] == '0)
      else $error("counter clear failed");
   a_cnt_hold: assert property ((cnt[0] == CNT_MAX && !cnt_clr) |=> cnt[0] == CNT_MAX)
      else $error("counter wrapped");
   a_evt_record: assert property ((((watch ^ watch_q) & evt_en) != '0) |=> event_valid_o && event_stamp_o == $past(stamp))
      else $error("input change not recorded");
   a_evt_suppress: assert property ((((watch ^ watch_q) & evt_en) == '0) |=> !event_valid_o)
      else $error("suppressed event emitted");

   c_shot: cover property (object_open_o ##[1:50] state == ST_DEAD);
   c_full_cycle: cover property (object_close_o ##[1:50] state == ST_RECLAIM);
   c_locked_unlock: cover property (state == ST_LOCKED ##[1:50] recloser_ready_ind_o);
   c_irq: cover property (irq_o);
endmodule // arioc_top
`default_nettype wire

/* sim/arioc_breaker_model.sv */
// Behavioural breaker object: follows the commands, can report a refused close
`timescale 1ns/1ps
`default_nettype none
module arioc_breaker_model #(
   parameter int DLY = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic open_cmd_i,
   input wire logic close_cmd_i,
   input wire logic manual_close_i,
   input wire logic fail_mode_i,
   output logic closed_o,
   output logic close_fail_o
);
   int cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         closed_o <= 1'b1;
         close_fail_o <= 1'b0;
         cnt <= 0;
      end else begin
         close_fail_o <= 1'b0;
         if (manual_close_i) begin
            closed_o <= 1'b1;
         end
         if ((open_cmd_i && closed_o) || (close_cmd_i && !closed_o)) begin
            cnt <= cnt + 1;
            if (cnt == DLY) begin
               cnt <= 0;
               // Supervision refuses the close and reports it instead
               if (close_cmd_i && fail_mode_i) begin
                  close_fail_o <= 1'b1;
               end else begin
                  closed_o <= close_cmd_i;
               end
            end
         end else begin
            cnt <= 0;
         end
      end
   end
endmodule // arioc_breaker_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the recloser I/O block with a breaker model
`timescale 1ns/1ps
`default_nettype none
`include "arioc_consts.svh"
`define CHK(n, e, s) check(n, 32'(e), 32'(s))
module tb import arioc_pkg::*;;
   logic clk_i, rst_i, cyc, stb, we, ack, irq, opn, cls, rdy, evv, bcl, cfail;
   logic mcl, fmode, en_in, unl, lck, crit, cfg, mop, ofail;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, d, stamp;
   logic [4:0] req;
   logic [12:0] evc, evl;
   int failures, total_checks, i, seen, ncyc, lag;
   // Each row is {expected source, request vector}; the last row is an eighth shot, which the shot count must hold at 7
   logic [7:0] rows [8] = '{8'h21, 8'h42, 8'h64, 8'h88, 8'hb0, 8'h7c, 8'h3f, 8'h21};
   logic [7:0] cexp [6] = '{8'h07, 8'h03, 8'h01, 8'h02, 8'h01, 8'h01};
   // Narrow counters so the row set reaches the shot counter's ceiling
   arioc_top #(.MS_CYCLES(4), .CNT_W(3)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .request_prio_i(req), .recloser_enable_in_i(en_in),
      .recloser_unlock_in_i(unl), .recloser_lock_in_i(lck), .critical_lockout_in_i(crit),
      .object_configured_i(cfg), .breaker_closed_i(bcl), .manual_open_i(mop),
      .manual_close_i(mcl), .open_fail_i(ofail), .close_fail_i(cfail), .object_open_o(opn),
      .object_close_o(cls), .recloser_ready_ind_o(rdy), .event_valid_o(evv),
      .event_change_o(evc), .event_level_o(evl), .event_stamp_o(stamp), .irq_o(irq));
   arioc_breaker_model brk (.clk_i(clk_i), .rst_i(rst_i), .open_cmd_i(opn),
      .close_cmd_i(cls), .manual_close_i(mcl), .fail_mode_i(fmode), .closed_o(bcl),
      .close_fail_o(cfail));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Clocks since reset release; four of them make one ms here
   always @(posedge clk_i) ncyc <= rst_i ? 0 : ncyc + 1;
   task automatic check(string n, logic [31:0] e, logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Holds the request until ack is sampled, then releases for at least a cycle
   task automatic wb(logic w, logic [7:0] a, logic [31:0] v);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (k >= 50) begin
         failures++;
         summarize();
      end
   endtask
   // Polls the state field; transient states shorter than a bus cycle are not awaited
   task automatic wait_st(logic [6:0] s);
      for (int k = 0; k < 150; k++) begin
         wb(1'b0, `ARIOC_ADR_STATUS, 32'h0);
         if (d[6:0] === s) begin
            break;
         end
      end
      `CHK("state", s, d[6:0]);
   endtask
   task automatic unlock();
      unl <= 1'b1;
      wait_st(ST_READY);
      unl <= 1'b0;
   endtask
   task automatic done(string s);
      $display("test %s finished", s);
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      failures++;
      summarize();
   end
   initial begin
      {cyc, stb, we, mcl, fmode, en_in, unl, lck, crit, mop, ofail} = '0;
      adr = '0;
      wdat = '0;
      req = '0;
      cfg = 1'b1;
      rst_i = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (cexp[k]) begin
         wb(1'b0, `ARIOC_ADR_CNT_BASE + 8'(4 * k), 32'h0);
         `CHK("count_reset", 0, d);
      end
      wait_st(ST_READY);
      `CHK("ready", 1, rdy);
      wb(1'b1, `ARIOC_ADR_DEAD, 32'h2);
      wb(1'b1, `ARIOC_ADR_RECLAIM, 32'h3);
      wb(1'b1, `ARIOC_ADR_IRQ_MASK, 32'h1);
      done("reset");
      foreach (rows[r]) begin
         req <= rows[r][4:0];
         for (i = 0; i < 6 && evv !== 1'b1; i++) @(posedge clk_i);
         `CHK("event_req", rows[r][4:0], evc[8:4]);
         `CHK("event_level", rows[r][4:0], evl[8:4]);
         lag = ncyc / 4 - int'(stamp);
         `CHK("event_stamp", 1, lag == 0 || lag == 1);
         for (i = 0; i < 20 && opn !== 1'b1; i++) @(posedge clk_i);
         `CHK("open_cmd", 1, opn);
         wb(1'b0, `ARIOC_ADR_STATUS, 32'h0);
         `CHK("source", rows[r][7:5], d[10:8]);
         `CHK("ready_busy", 0, rdy);
         for (i = 0; i < 80 && cls !== 1'b1; i++) @(posedge clk_i);
         `CHK("close_cmd", 1, cls);
         wait_st(ST_READY);
         `CHK("irq_shot", 1, irq);
         wb(1'b0, `ARIOC_ADR_IRQ_STAT, 32'h0);
         `CHK("irq_stat", 1, d[`ARIOC_IRQ_SHOT]);
         req <= 5'h00;
         repeat (4) @(posedge clk_i);
         `CHK("irq_clear", 0, irq);
      end
      done("requests");
      foreach (cexp[k]) begin
         wb(1'b0, `ARIOC_ADR_CNT_BASE + 8'(4 * k), 32'h0);
         `CHK("count", cexp[k], d);
      end
      wb(1'b1, `ARIOC_ADR_CNT_CLR, 32'h1);
      wb(1'b0, `ARIOC_ADR_CNT_BASE, 32'h0);
      `CHK("count_clr", 0, d);
      lck <= 1'b1;
      wait_st(ST_LOCKED);
      `CHK("ready_locked", 0, rdy);
      lck <= 1'b0;
      req <= 5'h01;
      repeat (5) @(posedge clk_i);
      `CHK("open_locked", 0, opn);
      req <= 5'h00;
      unlock();
      crit <= 1'b1;
      wait_st(ST_LOCKED);
      crit <= 1'b0;
      unlock();
      wb(1'b0, `ARIOC_ADR_CNT_BASE, 32'h0);
      `CHK("no_shot", 0, d);
      done("locking");
      cfg <= 1'b0;
      wait_st(ST_OFF);
      cfg <= 1'b1;
      wait_st(ST_READY);
      wb(1'b1, `ARIOC_ADR_CTRL, 32'h3);
      wait_st(ST_OFF);
      en_in <= 1'b1;
      wait_st(ST_READY);
      wb(1'b1, `ARIOC_ADR_CTRL, 32'h1);
      wb(1'b1, `ARIOC_ADR_EVT_EN, 32'h0);
      en_in <= 1'b0;
      seen = 0;
      repeat (6) @(posedge clk_i) seen += int'(evv === 1'b1);
      `CHK("event_off", 0, seen);
      wb(1'b1, `ARIOC_ADR_EVT_EN, 32'h1fff);
      done("enables");
      fmode <= 1'b1;
      req <= 5'h04;
      wait_st(ST_LOCKED);
      fmode <= 1'b0;
      req <= 5'h00;
      mcl <= 1'b1;
      @(posedge clk_i);
      mcl <= 1'b0;
      unlock();
      // Open supervision failure while the open command stands
      req <= 5'h01;
      for (i = 0; i < 20 && opn !== 1'b1; i++) @(posedge clk_i);
      ofail <= 1'b1;
      @(posedge clk_i);
      ofail <= 1'b0;
      req <= 5'h00;
      wait_st(ST_LOCKED);
      unlock();
      wb(1'b1, `ARIOC_ADR_DEAD, 32'h64);
      req <= 5'h02;
      wait_st(ST_DEAD);
      mcl <= 1'b1;
      @(posedge clk_i);
      mcl <= 1'b0;
      req <= 5'h00;
      wait_st(ST_RECLAIM);
      wait_st(ST_LOCKED);
      unlock();
      req <= 5'h08;
      wait_st(ST_DEAD);
      wb(1'b1, `ARIOC_ADR_DEAD, 32'h2);
      for (i = 0; i < 60 && cls !== 1'b1; i++) @(posedge clk_i);
      `CHK("close_new_dead", 1, cls);
      // Manual open while closing must abandon the sequence before the breaker closes
      mop <= 1'b1;
      @(posedge clk_i);
      mop <= 1'b0;
      req <= 5'h00;
      wb(1'b0, `ARIOC_ADR_STATUS, 32'h0);
      `CHK("manual_open", ST_READY, d[6:0]);
      wait_st(ST_READY);
      done("faults");
      summarize();
   end
endmodule // tb
`default_nettype wire
